/* File: bpt_pkg.sv */
// Shared constants and types of the buffered pulse train and square wave block.
// Assumes one 250 MHz clock and a 32-bit APB master that owns the register map.
package bpt_pkg;

	// Register byte offsets.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_DELAY = 8'h08;
	localparam logic [7:0] A_IDLE = 8'h0c;
	localparam logic [7:0] A_ACT = 8'h10;
	localparam logic [7:0] A_SIDLE = 8'h14;
	localparam logic [7:0] A_SACT = 8'h18;
	localparam logic [7:0] A_COUNT = 8'h1c;
	localparam logic [7:0] A_WIDTH = 8'h20;
	localparam logic [7:0] A_INC = 8'h24;
	localparam logic [7:0] A_FREQ = 8'h28;
	localparam logic [7:0] A_PFT = 8'h2c;

	// Control field positions.
	localparam int unsigned C_ARM = 0;
	localparam int unsigned C_MODE = 1;
	localparam int unsigned C_REGEN = 4;
	localparam int unsigned C_FALL = 6;

	// Status field positions.
	localparam int unsigned S_UNDER = 1;
	localparam int unsigned S_REFUSED = 2;

	// Square wave control field positions.
	localparam int unsigned F_DIV = 0;
	localparam int unsigned F_SEL = 4;
	localparam int unsigned F_EN = 6;

	// Reset values.
	localparam logic [31:0] RST_ZERO = 32'h0;
	localparam logic [7:0] RST_INC = 8'h00;

	typedef enum logic [2:0] {
		MD_IMP_FIN,
		MD_IMP_CONT,
		MD_SCK_FIN,
		MD_SCK_CONT,
		MD_EQS
	} bpt_mode_t;

	typedef enum logic [1:0] {RG_STD, RG_FIFO, RG_NONE} bpt_regen_t;

	typedef enum logic [1:0] {TB_20M, TB_10M, TB_100K} bpt_tbsel_t;

	typedef enum logic [1:0] {PR_OFF, PR_PULSE, PR_SQUARE} bpt_route_t;

	typedef struct packed {
		logic [31:0] idle;
		logic [31:0] active;
	} bpt_samp_t;

endpackage

/* File: bpt_gen.sv */
// Buffered pulse train engine, square wave generator and terminal drivers.
// Assumes source, gate, sample clock and timebase levels are synchronous.
//
// Decided for this implementation: the register offsets and register access over APB.
module bpt_gen #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned NPFT = 8
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Counter inputs.
	input wire logic source_i,
	input wire logic gate_i,
	input wire logic sample_clk_i,
	// Timebases.
	input wire logic tb20m_i,
	input wire logic tb100k_i,
	// Outputs.
	output logic pulse_o,
	output logic square_wave_output_o,
	output logic [NPFT-1:0] programmable_function_terminal_o,
	output logic [NPFT-1:0] programmable_function_terminal_oe_o
);

	typedef enum logic [2:0] {
		S_IDLE, S_DELAY, S_LOW, S_HIGH, S_WAIT, S_DONE
	} bpt_state_t;

	localparam int unsigned AW = $clog2(DEPTH);

	logic [31:0] ctrl_q, dly_q, idl0_q, act0_q, sidl_q, count_q, wid_q;
	logic [7:0] inc_q;
	logic [6:0] freq_q;
	logic [2*NPFT-1:0] pft_q;
	logic [31:0] prdata_q;
	bpt_state_t st_q, st_d;
	logic [31:0] tick_q, tick_d, idle_q, idle_d, act_q, act_d;
	logic [31:0] eqd_q, eqd_d, left_q, left_d;
	logic pend_q, under_q, refused_q, arm_q, pulse_q;
	logic src_q, gate_q, sck_q;
	bpt_pkg::bpt_samp_t mem [DEPTH];
	logic [AW-1:0] wp_q, rp_q, pp_q;
	logic [AW:0] cnt_q;
	logic pop, take, under_set;

	// Register access decode.
	wire acc = psel_i & penable_i;
	wire wr = acc & pwrite_i;
	wire hit = paddr_i inside {bpt_pkg::A_CTRL, bpt_pkg::A_STAT,
		bpt_pkg::A_DELAY, bpt_pkg::A_IDLE, bpt_pkg::A_ACT, bpt_pkg::A_SIDLE,
		bpt_pkg::A_SACT, bpt_pkg::A_COUNT, bpt_pkg::A_WIDTH, bpt_pkg::A_INC,
		bpt_pkg::A_FREQ, bpt_pkg::A_PFT};
	wire wr_stat = wr & (paddr_i == bpt_pkg::A_STAT);
	wire push_req = wr & (paddr_i == bpt_pkg::A_SACT);
	assign pready_o = 1'b1;
	assign pslverr_o = acc & ~hit;

	// Mode decode.
	wire arm = ctrl_q[bpt_pkg::C_ARM];
	wire arm_rise = arm & ~arm_q;
	wire [2:0] mode = ctrl_q[bpt_pkg::C_MODE +: 3];
	wire [1:0] regen = ctrl_q[bpt_pkg::C_REGEN +: 2];
	wire is_eqs = mode == bpt_pkg::MD_EQS;
	wire is_sck = mode == bpt_pkg::MD_SCK_FIN || mode == bpt_pkg::MD_SCK_CONT;
	wire fin = mode == bpt_pkg::MD_IMP_FIN || mode == bpt_pkg::MD_SCK_FIN;
	wire nonreg = regen == bpt_pkg::RG_NONE;
	wire fifo_rg = regen == bpt_pkg::RG_FIFO && !fin;
	wire run = st_q != S_IDLE && st_q != S_DONE;

	// Active source edge selection.
	wire fall = ctrl_q[bpt_pkg::C_FALL];
	wire src_edge = fall ? (src_q & ~source_i) : (~src_q & source_i);
	wire last = src_edge && tick_q <= 32'h1;
	wire gate_rise = gate_i & ~gate_q;
	wire sck_rise = sample_clk_i & ~sck_q;
	wire sck_ok = is_sck && run && (!fin || left_q != 32'h0);
	wire [31:0] inc32 = {24'h0, inc_q};

	// Sample store.
	wire empty = cnt_q == '0;
	wire full = cnt_q == (AW + 1)'(DEPTH);
	wire refuse = push_req & (full | (fifo_rg & run));
	wire push = push_req & ~refuse;
	wire bpt_pkg::bpt_samp_t head = fifo_rg ? mem[pp_q] : mem[rp_q];
	wire [AW-1:0] pp_nx = (pp_q + AW'(1) == wp_q) ? rp_q : pp_q + AW'(1);

	always_comb begin
		st_d = st_q;
		tick_d = tick_q;
		idle_d = idle_q;
		act_d = act_q;
		eqd_d = eqd_q;
		left_d = left_q;
		pop = 1'b0;
		take = 1'b0;
		under_set = 1'b0;
		unique case (st_q)
			S_IDLE: if (arm_rise) begin
				if (is_eqs) begin
					st_d = S_WAIT;
					eqd_d = dly_q;
				end else if (is_sck) begin
					st_d = S_DELAY;
					tick_d = dly_q;
					idle_d = idl0_q;
					act_d = act0_q;
					left_d = count_q;
				end else begin
					st_d = S_WAIT;
				end
			end
			S_DELAY: if (src_edge) begin
				if (!last) begin
					tick_d = tick_q - 32'h1;
				end else if (is_eqs) begin
					st_d = S_HIGH;
					tick_d = wid_q;
				end else begin
					st_d = S_LOW;
					tick_d = idle_q;
				end
			end
			S_LOW: if (src_edge) begin
				if (!last) begin
					tick_d = tick_q - 32'h1;
				end else begin
					st_d = S_HIGH;
					tick_d = act_q;
				end
			end
			S_HIGH: if (src_edge) begin
				if (!last) begin
					tick_d = tick_q - 32'h1;
				end else if (is_eqs) begin
					st_d = S_WAIT;
					eqd_d = eqd_q + inc32;
				end else if (is_sck) begin
					take = pend_q;
					if (pend_q && !empty) begin
						pop = 1'b1;
						idle_d = head.idle;
						act_d = head.active;
					end else if (pend_q) begin
						under_set = nonreg;
					end
					st_d = S_LOW;
					tick_d = idle_d;
				end else if (!empty) begin
					pop = 1'b1;
					idle_d = head.idle;
					act_d = head.active;
					st_d = S_LOW;
					tick_d = idle_d;
				end else if (fin) begin
					st_d = S_DONE;
				end else begin
					st_d = S_WAIT;
					under_set = nonreg;
				end
			end
			S_WAIT: if (is_eqs) begin
				if (gate_rise) begin
					st_d = S_DELAY;
					tick_d = eqd_q;
				end
			end else if (!empty) begin
				pop = 1'b1;
				idle_d = head.idle;
				act_d = head.active;
				st_d = S_LOW;
				tick_d = idle_d;
			end else if (fin) begin
				st_d = S_DONE;
			end else begin
				under_set = nonreg;
			end
			S_DONE: st_d = S_DONE;
			default: st_d = S_IDLE;
		endcase
		if (sck_ok && sck_rise && fin) begin
			left_d = left_q - 32'h1;
		end
		if (!arm) begin
			st_d = S_IDLE;
		end
	end

	wire pend_d = (sck_ok & sck_rise) | (pend_q & ~take);
	wire under_d = under_set | (under_q & ~(wr_stat & pwdata_i[bpt_pkg::S_UNDER]));
	wire ref_d = refuse | (refused_q & ~(wr_stat & pwdata_i[bpt_pkg::S_REFUSED]));

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= S_IDLE;
			tick_q <= bpt_pkg::RST_ZERO;
			idle_q <= bpt_pkg::RST_ZERO;
			act_q <= bpt_pkg::RST_ZERO;
			eqd_q <= bpt_pkg::RST_ZERO;
			left_q <= bpt_pkg::RST_ZERO;
			{pend_q, under_q, refused_q, arm_q, pulse_q} <= 5'h0;
			{src_q, gate_q, sck_q} <= 3'h0;
		end else begin
			st_q <= st_d;
			tick_q <= tick_d;
			idle_q <= idle_d;
			act_q <= act_d;
			eqd_q <= eqd_d;
			left_q <= left_d;
			{pend_q, under_q, refused_q} <= {pend_d, under_d, ref_d};
			{arm_q, pulse_q} <= {arm, st_d == S_HIGH};
			{src_q, gate_q, sck_q} <= {source_i, gate_i, sample_clk_i};
		end
	end

	// Sample store pointers; standard regeneration consumes, FIFO replays in continuous modes.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{wp_q, rp_q, pp_q} <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= push ? wp_q + AW'(1) : wp_q;
			rp_q <= (pop && !fifo_rg) ? rp_q + AW'(1) : rp_q;
			pp_q <= arm_rise ? rp_q : ((pop && fifo_rg) ? pp_nx : pp_q);
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop && !fifo_rg);
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem[wp_q] <= '{idle: sidl_q, active: pwdata_i};
		end
	end

	// Read selection.
	wire [31:0] stat = {16'h0, 7'(cnt_q), 4'h0, full, empty,
		refused_q, under_q, run};
	wire [31:0] rd =
		paddr_i == bpt_pkg::A_CTRL ? ctrl_q :
		paddr_i == bpt_pkg::A_STAT ? stat :
		paddr_i == bpt_pkg::A_DELAY ? dly_q :
		paddr_i == bpt_pkg::A_IDLE ? idl0_q :
		paddr_i == bpt_pkg::A_ACT ? act0_q :
		paddr_i == bpt_pkg::A_SIDLE ? sidl_q :
		paddr_i == bpt_pkg::A_COUNT ? count_q :
		paddr_i == bpt_pkg::A_WIDTH ? wid_q :
		paddr_i == bpt_pkg::A_INC ? inc32 :
		paddr_i == bpt_pkg::A_FREQ ? {25'h0, freq_q} :
		paddr_i == bpt_pkg::A_PFT ? 32'(pft_q) : 32'h0;

	// Registers.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{ctrl_q, dly_q, idl0_q, act0_q} <= '0;
			{sidl_q, count_q, wid_q} <= '0;
			inc_q <= bpt_pkg::RST_INC;
			freq_q <= '0;
			pft_q <= '0;
			prdata_q <= bpt_pkg::RST_ZERO;
		end else begin
			if (wr) begin
				unique case (paddr_i)
					bpt_pkg::A_CTRL: ctrl_q <= pwdata_i;
					bpt_pkg::A_DELAY: dly_q <= pwdata_i;
					bpt_pkg::A_IDLE: idl0_q <= pwdata_i;
					bpt_pkg::A_ACT: act0_q <= pwdata_i;
					bpt_pkg::A_SIDLE: sidl_q <= pwdata_i;
					bpt_pkg::A_COUNT: count_q <= pwdata_i;
					bpt_pkg::A_WIDTH: wid_q <= pwdata_i;
					bpt_pkg::A_INC: inc_q <= pwdata_i[7:0];
					bpt_pkg::A_FREQ: freq_q <= pwdata_i[6:0];
					bpt_pkg::A_PFT: pft_q <= pwdata_i[2*NPFT-1:0];
					default: ;
				endcase
			end
			if (psel_i && !penable_i) begin
				prdata_q <= rd;
			end
		end
	end

	assign prdata_o = prdata_q;
	assign pulse_o = pulse_q;

	// Square wave generator, separate from the pulse engine.
	logic tb20_q, half_q, lvl_q, sq_q, fen_q;
	logic [1:0] fsel_q;
	logic [4:0] fd_q;
	logic [3:0] fcnt_q;
	wire [1:0] fsel = fen_q ? fsel_q : freq_q[bpt_pkg::F_SEL +: 2];
	wire lvl = fsel == bpt_pkg::TB_20M ? tb20m_i :
		fsel == bpt_pkg::TB_10M ? half_q : tb100k_i;
	wire ftick = lvl & ~lvl_q;
	wire [4:0] low_len = (fd_q + 5'h1) >> 1;
	wire wrap = ftick && {1'b0, fcnt_q} + 5'h1 >= fd_q;
	wire reload = !fen_q || wrap;
	wire sq_d = !fen_q ? 1'b0 :
		fd_q == 5'h1 ? lvl : {1'b0, fcnt_q} >= low_len;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			{tb20_q, half_q, lvl_q, sq_q, fen_q} <= 5'h0;
			fsel_q <= 2'h0;
			fd_q <= 5'h1;
			fcnt_q <= 4'h0;
		end else begin
			tb20_q <= tb20m_i;
			half_q <= half_q ^ (tb20m_i & ~tb20_q);
			lvl_q <= lvl;
			sq_q <= sq_d;
			if (reload) begin
				fen_q <= freq_q[bpt_pkg::F_EN];
				fsel_q <= freq_q[bpt_pkg::F_SEL +: 2];
				fd_q <= {1'b0, freq_q[bpt_pkg::F_DIV +: 4]} + 5'h1;
				fcnt_q <= 4'h0;
			end else if (ftick) begin
				fcnt_q <= fcnt_q + 4'h1;
			end
		end
	end
	assign square_wave_output_o = sq_q;

	// Terminal routing.
	for (genvar i = 0; i < NPFT; i++) begin : g_pft
		wire [1:0] sel = pft_q[2*i +: 2];
		assign programmable_function_terminal_o[i] =
			sel == bpt_pkg::PR_SQUARE ? sq_q : pulse_q;
		assign programmable_function_terminal_oe_o[i] =
			sel == bpt_pkg::PR_PULSE || sel == bpt_pkg::PR_SQUARE;
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	edge_hold_a: assert property (
		(st_q inside {S_DELAY, S_LOW, S_HIGH} && !src_edge && arm)
		|=> st_q == $past(st_q) && tick_q == $past(tick_q))
		else $error("State moved without a source edge.");
	imp_stop_a: assert property (
		(st_q == S_HIGH && last && mode == bpt_pkg::MD_IMP_FIN && empty && arm)
		|=> st_q == S_DONE ##1 !pulse_q)
		else $error("Finite implicit run did not stop.");
	sck_hold_a: assert property (
		(st_q == S_HIGH && is_sck && last && !pend_q && arm)
		|=> st_q == S_LOW && idle_q == $past(idle_q) && act_q == $past(act_q))
		else $error("Specification changed without a sample clock.");
	under_flag_a: assert property (
		(st_q == S_WAIT && !is_eqs && empty && !fin && nonreg && arm)
		|=> under_q)
		else $error("Starved output did not flag underflow.");
	refuse_wr_a: assert property (
		(push_req && fifo_rg && run)
		|=> cnt_q == $past(cnt_q) && refused_q)
		else $error("Write accepted during replay.");
	delay_grow_a: assert property (
		(is_eqs && st_q == S_HIGH && last && arm)
		|=> eqd_q == $past(eqd_q) + $past(inc32) && st_q == S_WAIT)
		else $error("Delay did not grow by the increment.");
	gate_ignore_a: assert property (
		(is_eqs && st_q == S_HIGH && gate_rise && !src_edge && arm)
		|=> st_q == S_HIGH)
		else $error("Gate edge disturbed a pulse in progress.");
	odd_low_a: assert property (
		(fen_q && fd_q > 5'h1 && {1'b0, fcnt_q} < low_len) |=> !sq_q)
		else $error("Square wave high during its low share.");

endmodule

/* File: bpt_host.sv */
// Host model: APB master that feeds pulse samples to the block.
// Assumes xfer is called just after a rising edge of clk_i.
module bpt_host (
	// Clock.
	input wire logic clk_i,
	// APB master side.
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o,
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end

	// One transfer, held until pready is seen high or 64 cycles have passed.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		r = prdata_i;
		e = (n < 64) ? pslverr_i : 1'bx;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		@(posedge clk_i);
	endtask

	// Samples go out as whole pairs, idle word first.
	task automatic push(input logic [31:0] idle, input logic [31:0] act);
		logic [31:0] r;
		logic e;
		xfer(1'b1, bpt_pkg::A_SIDLE, idle, r, e);
		xfer(1'b1, bpt_pkg::A_SACT, act, r, e);
	endtask
endmodule

/* File: test_buffered_pulse_train_and_freq_gen.sv */
// Self-checking bench for the pulse train and square wave block.
// Assumes bpt_pkg, bpt_gen and the bpt_host model are compiled first.
module test_buffered_pulse_train_and_freq_gen;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, pulse, sq;
	logic [7:0] paddr, pft, pft_oe;
	logic [31:0] pwdata, prdata;
	logic gate = 1'b0;
	logic sclk = 1'b0;
	logic msel = 1'b0;
	logic [3:0] ph = 4'h0;
	logic [7:0] seed = 8'h17;
	int failures = 0;
	int tests_run = 0;
	wire logic mon = msel ? sq : pulse;

	always #2 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) ph <= ph + 4'h1;

	bpt_gen #(.DEPTH(16), .NPFT(8)) i_bpt_gen (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.source_i(ph[1]), .gate_i(gate), .sample_clk_i(sclk),
		.tb20m_i(ph[1]), .tb100k_i(ph[3]), .pulse_o(pulse),
		.square_wave_output_o(sq),
		.programmable_function_terminal_o(pft),
		.programmable_function_terminal_oe_o(pft_oe));
	bpt_host i_bpt_host (.clk_i(ref_clk_i), .psel_o(psel),
		.penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
		.pslverr_i(pslverr));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		i_bpt_host.xfer(1'b1, a, d, r, e);
		if (e === 1'bx)
			failures++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		i_bpt_host.xfer(1'b0, a, 32'h0, r, e);
		if (e === 1'bx)
			failures++;
	endtask

	// Counts cycles while the watched output stays at lvl.
	task automatic span(input logic lvl, output int n);
		n = 0;
		while (mon === lvl && n < 3000) begin
			@(posedge ref_clk_i);
			n++;
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge ref_clk_i);
		failures++;
		give_verdict;
	end

	initial begin
		int n, d, d0;
		int hq[$];
		int lq[$];
		int fd[5] = '{5, 4, 1, 2, 2};
		int fs[5] = '{0, 0, 0, 1, 2};
		int fh[5] = '{8, 8, 2, 8, 16};
		int fl[5] = '{12, 8, 2, 8, 16};
		logic [31:0] r;
		logic e;
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(posedge ref_clk_i);
		check("oe", {24'h0, pft_oe}, 32'h0);
		i_bpt_host.xfer(1'b0, 8'h3c, 32'h0, r, e);
		check("slverr", {31'h0, e}, 32'h1);
		rd(bpt_pkg::A_INC, r);
		check("inc", r, {24'h0, bpt_pkg::RST_INC});
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			lq.push_back(int'(seed[1:0]) + 1);
			hq.push_back(int'(seed[3:2]) + 1);
			i_bpt_host.push(lq[i], hq[i]);
		end
		wr(bpt_pkg::A_CTRL, 32'h1);
		span(1'b0, n);
		for (int i = 0; i < 3; i++) begin
			span(1'b1, n);
			check("high", n, hq[i] * 4);
			span(1'b0, n);
			check("low", n, i < 2 ? lq[i + 1] * 4 : 3000);
		end
		wr(bpt_pkg::A_CTRL, 32'h0);
		$display("test implicit done");
		wr(bpt_pkg::A_DELAY, 32'h1);
		wr(bpt_pkg::A_IDLE, 32'h2);
		wr(bpt_pkg::A_ACT, 32'h2);
		wr(bpt_pkg::A_COUNT, 32'h1);
		i_bpt_host.push(32'h3, 32'h3);
		wr(bpt_pkg::A_CTRL, 32'h5);
		span(1'b0, n);
		span(1'b1, n);
		check("init", n, 8);
		sclk <= 1'b1;
		@(posedge ref_clk_i);
		sclk <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			span(1'b0, n);
			if (k > 0)
				check("sidle", n, 12);
			span(1'b1, n);
			check("sact", n, k == 0 ? 8 : 12);
		end
		wr(bpt_pkg::A_CTRL, 32'h0);
		$display("test sampled done");
		wr(bpt_pkg::A_DELAY, 32'h2);
		wr(bpt_pkg::A_WIDTH, 32'h2);
		wr(bpt_pkg::A_INC, 32'h3);
		for (int t = 0; t < 4; t++) begin
			if (t == 3)
				wr(bpt_pkg::A_CTRL, 32'h0);
			if (t % 3 == 0)
				wr(bpt_pkg::A_CTRL, 32'h9);
			n = 0;
			while (ph !== 4'hf && n < 20) begin
				@(posedge ref_clk_i);
				n++;
			end
			if (n == 20)
				failures++;
			gate <= 1'b1;
			@(posedge ref_clk_i);
			gate <= 1'b0;
			repeat (3) @(posedge ref_clk_i);
			gate <= 1'b1;
			@(posedge ref_clk_i);
			gate <= 1'b0;
			span(1'b0, d);
			span(1'b1, n);
			check("width", n, 8);
			if (t == 0)
				d0 = d;
			check("delay", d - d0, (t % 3) * 12);
		end
		wr(bpt_pkg::A_CTRL, 32'h0);
		$display("test sampling done");
		wr(bpt_pkg::A_PFT, 32'h6);
		check("oe2", {24'h0, pft_oe}, 32'h3);
		msel = 1'b1;
		for (int j = 0; j < 5; j++) begin
			wr(bpt_pkg::A_FREQ, (fd[j] - 1) | (fs[j] << 4) | 64);
			repeat (2) begin
				span(1'b1, n);
				span(1'b0, n);
			end
			span(1'b1, n);
			check("sqhi", n, fh[j]);
			span(1'b0, n);
			check("sqlo", n, fl[j]);
			check("pft", {31'h0, pft[0]}, {31'h0, sq});
		end
		msel = 1'b0;
		wr(bpt_pkg::A_FREQ, 32'h0);
		$display("test square done");
		i_bpt_host.push(32'h1, 32'h1);
		wr(bpt_pkg::A_CTRL, 32'h23);
		repeat (200) @(posedge ref_clk_i);
		rd(bpt_pkg::A_STAT, r);
		check("under", {31'h0, r[bpt_pkg::S_UNDER]}, 32'h1);
		check("run", {31'h0, r[0]}, 32'h1);
		wr(bpt_pkg::A_CTRL, 32'h0);
		wr(bpt_pkg::A_STAT, 32'h2);
		rd(bpt_pkg::A_STAT, r);
		check("uclr", {31'h0, r[bpt_pkg::S_UNDER]}, 32'h0);
		$display("test underflow done");
		i_bpt_host.push(32'h1, 32'h1);
		wr(bpt_pkg::A_CTRL, 32'h13);
		i_bpt_host.push(32'h1, 32'h1);
		rd(bpt_pkg::A_STAT, r);
		check("refused", {31'h0, r[bpt_pkg::S_REFUSED]}, 32'h1);
		span(1'b0, n);
		span(1'b1, n);
		check("replay", n, 4);
		wr(bpt_pkg::A_CTRL, 32'h0);
		$display("test regen done");
		give_verdict;
	end
endmodule
